// ### src/pfc_tx_request_logic.sv
// priority flow control request logic of a 10G-class MAC
// assumes client requests and receive decode results are synchronous to i_clk
// What this block does
// [R1] PFC and whole-link pause together is unsupported; PFC is then held off.
// [R2] Separate enables for transmitting and receiving PFC frames.
// [R3] Each of eight priorities can be paused on its own.
// [R4] Enable vector is 16 bits, eight low bits used, rest zero.
// [R5] Eight 16-bit quanta fields follow, priority 0 first.
// [R6] One quantum is 512 bit times, 51.2 ns at 10 Gb/s; the tick here counts it as one 100 ns cycle.
// [R7] Frames only while transmit PFC on and the priority enabled.
// [R8] Request held over one cycle is XOFF, refreshed in every frame.
// [R9] Single-cycle request sends one frame, no automatic refresh.
// [R10] Held request resends frame when quanta count reaches refresh value.
// [R11] Per-priority pause value and refresh value are configurable.
// [R12] Release of held request with auto-XON sends zero-quanta frame.
// [R13] Every frame carries all active priorities and restarts the count.
// [R14] Request inputs are sampled on the transmit clock.
// [R15] Refresh frames enable only currently active priorities.
// [R16] One receive pause output per priority.
// [R17] Client holds request high while its queue is nearly full.
// [R18] Received nonzero quanta loads a down-counter; pause while nonzero.
// [R19] Control frames recognised only with type 88-08.
// [R20] Pending frame waits for frame boundary, goes ahead of client frames.
// [R21] Single-cycle requests are latched until their frame is sent.
`timescale 1ns/1ps
module pfc_tx_request_logic (
    input  wire logic                                 i_clk,
    input  wire logic                                 i_rstn,
    input  wire logic                                 i_tx_pfc_en,
    input  wire logic                                 i_rx_pfc_en,
    input  wire logic                                 i_link_pause_en,
    input  wire logic                                 i_auto_xon_en,
    input  wire logic [pfc_pkg::NUM_PRIO-1:0]         i_prio_tx_en,
    input  wire logic [pfc_pkg::NUM_PRIO*pfc_pkg::QW-1:0] i_pause_quanta,
    input  wire logic [pfc_pkg::NUM_PRIO*pfc_pkg::QW-1:0] i_refresh_quanta,
    input  wire logic [pfc_pkg::NUM_PRIO-1:0]         i_req,
    input  wire logic                                 i_tx_busy,
    input  wire logic                                 i_rx_frame_valid,
    input  wire logic [15:0]                          i_rx_len_type,
    input  wire logic [15:0]                          i_rx_enable_vec,
    input  wire logic [pfc_pkg::NUM_PRIO*pfc_pkg::QW-1:0] i_rx_quanta,
    output logic [15:0]                               o_ctl_word,
    output logic                                      o_ctl_valid,
    output logic                                      o_ctl_first,
    output logic                                      o_ctl_last,
    output logic                                      o_ctl_hold,
    output logic                                      o_mode_conflict,
    output logic [pfc_pkg::NUM_PRIO-1:0]              o_rx_pause
);
    import pfc_pkg::*;

    tx_state_e             state_q;
    logic [NUM_PRIO-1:0]   req_q;
    logic [NUM_PRIO-1:0]   held_q;
    logic [NUM_PRIO-1:0]   one_q;
    logic [NUM_PRIO-1:0]   xon_q;
    logic [NUM_PRIO-1:0]   en_vec_q;
    logic [QW-1:0]         snap_q [NUM_PRIO];
    logic [3:0]            idx_q;
    logic [15:0]           qcnt_q;
    logic [15:0]           div_q;
    logic                  tick_q;
    logic [NUM_PRIO-1:0]   prio_ok;
    logic [NUM_PRIO-1:0]   active;
    logic [NUM_PRIO-1:0]   refresh_hit;
    logic [NUM_PRIO-1:0]   rise;
    logic [NUM_PRIO-1:0]   fall_xon;
    logic                  tx_on;
    logic                  rx_on;
    logic                  pending;
    logic                  start;
    logic                  rx_take;

    // [R2] separate direction enables
    // [R1] whole-link pause locks PFC out
    assign tx_on = i_tx_pfc_en && !i_link_pause_en;
    assign rx_on = i_rx_pfc_en && !i_link_pause_en;

    // [R3] per-priority inhibit
    // [R7] per-priority gate
    assign prio_ok = tx_on ? i_prio_tx_en : PRIO_RST;

    // [R14] edges of the sampled requests
    assign rise     = i_req & ~req_q;
    assign fall_xon = held_q & ~i_req & {NUM_PRIO{i_auto_xon_en}};
    // [R8] held requests count as active
    assign active   = i_req & req_q & prio_ok;

    // [R10] refresh compare against the common quanta count
    always_comb begin
        for (int p = 0; p < NUM_PRIO; p++) begin
            refresh_hit[p] = held_q[p] && prio_ok[p]
                             && qcnt_q >= i_refresh_quanta[p*QW +: QW];
        end
    end

    // [R20] a frame is owed while an enabled one-shot or XON is latched or a refresh is due
    assign pending = |((one_q | xon_q | refresh_hit | active) & prio_ok)
                     && ((|((one_q | xon_q) & prio_ok)) || (|refresh_hit));
    assign start   = (state_q == ST_IDLE) && pending && !i_tx_busy;

    // [R9] request history; a one-cycle pulse never reaches held_q
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            req_q  <= PRIO_RST;
            held_q <= PRIO_RST;
        end else begin
            req_q  <= i_req;
            held_q <= i_req & req_q;
        end
    end

    // [R21] latch one-shot requests, set wins over clear
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            one_q <= PRIO_RST;
        end else begin
            one_q <= (start ? PRIO_RST : one_q) | (rise & prio_ok);
        end
    end

    // [R12] owed XON after a held release
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            xon_q <= PRIO_RST;
        end else begin
            xon_q <= ((start ? PRIO_RST : xon_q) | (fall_xon & prio_ok)) & ~i_req;
        end
    end

    // [R6] quantum tick divider
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            div_q  <= WORD_RST;
            tick_q <= 1'b0;
        end else if (div_q >= 16'(QUANTUM_CYC - 1)) begin
            div_q  <= WORD_RST;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // [R13] count restarts on every frame; saturates at the top
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            qcnt_q <= WORD_RST;
        end else if (start) begin
            qcnt_q <= WORD_RST;
        end else if (tick_q && qcnt_q != 16'hFFFF) begin
            qcnt_q <= qcnt_q + 16'h0001;
        end
    end

    // [R15] snapshot enables and quanta when the frame starts
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            en_vec_q <= PRIO_RST;
            for (int p = 0; p < NUM_PRIO; p++) begin
                snap_q[p] <= WORD_RST;
            end
        end else if (start) begin
            en_vec_q <= (i_req | one_q | xon_q) & prio_ok;
            for (int p = 0; p < NUM_PRIO; p++) begin
                // [R11] programmed pause value, zero for XON
                snap_q[p] <= (xon_q[p] && !i_req[p]) ? XON_QUANTA
                             : i_pause_quanta[p*QW +: QW];
            end
        end
    end

    // frame sequencer
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
            idx_q   <= 4'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_SEND;
                        idx_q   <= 4'h0;
                    end
                end
                ST_SEND: begin
                    if (idx_q == 4'(FRAME_WORDS - 1)) begin
                        state_q <= ST_IDLE;
                    end else begin
                        idx_q <= idx_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // [R4] [R5] word stream: enable vector, then quanta p0..p7
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_ctl_word  <= WORD_RST;
            o_ctl_valid <= 1'b0;
            o_ctl_first <= 1'b0;
            o_ctl_last  <= 1'b0;
        end else if (state_q == ST_SEND) begin
            o_ctl_valid <= 1'b1;
            o_ctl_first <= (idx_q == 4'h0);
            o_ctl_last  <= (idx_q == 4'(FRAME_WORDS - 1));
            if (idx_q == 4'h0) begin
                o_ctl_word <= {8'h00, en_vec_q};
            end else begin
                o_ctl_word <= snap_q[3'(idx_q - 4'h1)];
            end
        end else begin
            o_ctl_valid <= 1'b0;
            o_ctl_first <= 1'b0;
            o_ctl_last  <= 1'b0;
        end
    end

    // [R20] stall client frames while a control frame is owed or going out
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_ctl_hold      <= 1'b0;
            o_mode_conflict <= 1'b0;
        end else begin
            o_ctl_hold      <= pending || (state_q == ST_SEND);
            // [R1] flag the unsupported combination
            o_mode_conflict <= i_link_pause_en && (i_tx_pfc_en || i_rx_pfc_en);
        end
    end

    // [R19] receive side accepts only MAC control frames
    assign rx_take = i_rx_frame_valid && rx_on && i_rx_len_type == MAC_CTRL_TYPE;

    // [R16] one pause timer per priority
    for (genvar g = 0; g < NUM_PRIO; g++) begin : g_rx
        pfc_rx_if rx_bus ();
        assign rx_bus.load   = rx_take && i_rx_enable_vec[g];
        assign rx_bus.quanta = i_rx_quanta[g*QW +: QW];
        assign rx_bus.tick   = tick_q;
        assign o_rx_pause[g] = rx_bus.pause;
        pfc_pause_timer u_timer (
            .i_clk  (i_clk),
            .i_rstn (i_rstn),
            .bus    (rx_bus.ctl)
        );
    end

    // checks
    sequence s_frame_start;
        state_q == ST_IDLE && start;
    endsequence
    sequence s_frame_words;
        o_ctl_valid && o_ctl_first ##1 o_ctl_valid [*7] ##1 o_ctl_valid && o_ctl_last;
    endsequence

    AST_FRAME_SHAPE: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R5]
        s_frame_start |=> ##1 s_frame_words)
        else $error("control frame not nine words");
    AST_VEC_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R4]
        o_ctl_first |-> o_ctl_word[15:8] == 8'h00)
        else $error("enable vector upper bits not zero");
    AST_NO_TX_WHEN_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R7]
        !tx_on |-> !start)
        else $error("frame started with transmit PFC off");
    AST_WAIT_BOUNDARY: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R20]
        i_tx_busy |-> !start)
        else $error("frame started while transmitter busy");
    AST_ONE_SHOT_KEPT: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R21]
        rise[0] && prio_ok[0] && !start |=> one_q[0])
        else $error("single-cycle request lost");
    AST_COUNT_RESTART: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R13]
        start |=> qcnt_q == WORD_RST)
        else $error("quanta count not restarted");
    AST_XON_ZERO: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R12]
        start && xon_q[0] && !i_req[0] |=> snap_q[0] == XON_QUANTA && en_vec_q[0])
        else $error("XON quanta not zero");
    AST_REFRESH_ONLY_ACTIVE: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R15]
        start |=> (en_vec_q & ~($past(i_req) | $past(one_q) | $past(xon_q))) == PRIO_RST)
        else $error("inactive priority enabled in frame");
    AST_RX_TYPE_ONLY: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R19]
        i_rx_frame_valid && i_rx_len_type != MAC_CTRL_TYPE |-> !rx_take)
        else $error("non-control frame accepted");

    // hold, history, XOFF, flag and marker checks
    AST_HOLD_IN_SEND: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R20]
        state_q == ST_SEND |=> o_ctl_hold)
        else $error("client frames not held during control frame");
    AST_ONE_CYCLE_NOT_HELD: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R9]
        i_req[0] && !req_q[0] |=> !held_q[0])
        else $error("single-cycle request treated as held");
    AST_XOFF_IN_FRAME: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R8]
        start && i_req[0] && prio_ok[0] |=> en_vec_q[0])
        else $error("held request missing from frame");
    AST_CONFLICT_FLAG: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R1]
        i_link_pause_en && i_tx_pfc_en |=> o_mode_conflict)
        else $error("mode conflict not flagged");
    AST_MARKER_VALID: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R4]
        o_ctl_first || o_ctl_last |-> o_ctl_valid)
        else $error("frame marker without valid word");
endmodule

// ### src/pfc_pkg.sv
// constants shared by the priority flow control request logic
// assumes one 10 MHz transmit clock and a 10 Gb/s link
package pfc_pkg;
    localparam int          NUM_PRIO      = 8;
    localparam int          QW            = 16;
    localparam logic [15:0] MAC_CTRL_TYPE = 16'h8808;
    localparam logic [15:0] XON_QUANTA    = 16'h0000;
    localparam logic [7:0]  PRIO_RST      = 8'h00;
    localparam logic [15:0] WORD_RST      = 16'h0000;
    // one quantum is 512 bit times on the link
    localparam int          QUANTUM_BITS  = 512;
    localparam int          LINK_GBPS     = 10;
    localparam int          QUANTUM_PS    = QUANTUM_BITS * 1000 / LINK_GBPS;
    localparam int          CLK_PERIOD_PS = 100000;
    // rounds down to whole cycles, never below one cycle
    localparam int          QUANTUM_CYC   = (QUANTUM_PS / CLK_PERIOD_PS < 1) ? 1
                                            : QUANTUM_PS / CLK_PERIOD_PS;
    // enable vector then eight quanta fields
    localparam int          FRAME_WORDS   = 1 + NUM_PRIO;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } tx_state_e;
endpackage

// ### src/pfc_rx_if.sv
// link between the request logic and one receive pause timer
// assumes both ends share i_clk
`timescale 1ns/1ps
interface pfc_rx_if;
    logic        load;
    logic [15:0] quanta;
    logic        tick;
    logic        pause;
    modport ctl (output load, output quanta, output tick, input pause);
    modport cnt (input load, input quanta, input tick, output pause);
endinterface

// ### src/pfc_pause_timer.sv
// per-priority receive pause down-counter
// assumes load and tick come from the request logic on i_clk
`timescale 1ns/1ps
module pfc_pause_timer (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    pfc_rx_if.cnt     bus
);
    import pfc_pkg::*;

    logic [QW-1:0] cnt_q;
    logic          pause_q;

    // [R18] load and count down
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_q   <= WORD_RST;
            pause_q <= 1'b0;
        end else if (bus.load) begin
            // a zero load releases the queue at once
            cnt_q   <= bus.quanta;
            pause_q <= (bus.quanta != XON_QUANTA);
        end else if (bus.tick && cnt_q != WORD_RST) begin
            cnt_q   <= cnt_q - 16'h0001;
            pause_q <= (cnt_q != 16'h0001);
        end
    end

    assign bus.pause = pause_q;

    AST_PAUSE_ON_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R18]
        bus.load && bus.quanta != XON_QUANTA |=> pause_q)
        else $error("pause not raised after nonzero load");
    AST_PAUSE_TRACKS_CNT: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R18]
        pause_q == (cnt_q != WORD_RST))
        else $error("pause output disagrees with counter");
endmodule

// ### dv/pfc_link_partner.sv
// far-side model: collects control frames and stalls the sender
// assumes one word per i_clk while i_valid is high, last on the ninth
`timescale 1ns/1ps
module pfc_link_partner (
    input  wire logic        i_clk,
    input  wire logic        i_stall,
    input  wire logic [15:0] i_word,
    input  wire logic        i_valid,
    input  wire logic        i_first,
    input  wire logic        i_last,
    output logic             o_busy,
    output logic [15:0]      o_words [9],
    output int               o_frames,
    output int               o_bad
);
    int idx = 0;
    int frames = 0;
    int bad = 0;
    assign o_frames = frames;
    assign o_bad    = bad;
    // busy while our own frame goes out
    assign o_busy = i_stall;
    // sampled on the rising edge; last marks word 8 only
    always @(posedge i_clk) begin
        if (i_valid) begin
            idx = i_first ? 0 : idx + 1;
            if (idx < 9) begin
                o_words[idx] <= i_word;
            end
            if (i_last !== (idx == 8) || idx > 8) begin
                bad <= bad + 1;
            end
            if (idx == 8) begin
                frames <= frames + 1;
            end
        end
    end
endmodule

// ### dv/test_pfc_tx_request_logic.sv
// self-checking bench for the pfc request logic
// assumes the partner model counts each whole control frame
`timescale 1ns/1ps
module test_pfc_tx_request_logic;
    import pfc_pkg::*;
    logic         clk = 1'b0, rstn = 1'b0, stall = 1'b0, rxv = 1'b0;
    logic         tx_en = 1'b1, rx_en = 1'b1, lp_en = 1'b0, axon = 1'b0;
    logic [7:0]   pen = 8'hFF, req = 8'h00, pause;
    logic [127:0] pq, rq, rxq = '0;
    logic [15:0]  rxt = 16'h0000, rxe = 16'h0000, word;
    logic [15:0]  words [9];
    logic         valid, first, last, hold, conf, busy;
    int           cnt, bad, errors = 0, compares = 0, waited;

    always #50 clk = ~clk;

    pfc_tx_request_logic DUT (.i_clk(clk), .i_rstn(rstn), .i_tx_pfc_en(tx_en),
        .i_rx_pfc_en(rx_en), .i_link_pause_en(lp_en), .i_auto_xon_en(axon),
        .i_prio_tx_en(pen), .i_pause_quanta(pq), .i_refresh_quanta(rq), .i_req(req),
        .i_tx_busy(busy), .i_rx_frame_valid(rxv), .i_rx_len_type(rxt),
        .i_rx_enable_vec(rxe), .i_rx_quanta(rxq), .o_ctl_word(word), .o_ctl_valid(valid),
        .o_ctl_first(first), .o_ctl_last(last), .o_ctl_hold(hold),
        .o_mode_conflict(conf), .o_rx_pause(pause));
    pfc_link_partner lp (.i_clk(clk), .i_stall(stall), .i_word(word), .i_valid(valid),
        .i_first(first), .i_last(last), .o_busy(busy), .o_words(words), .o_frames(cnt),
        .o_bad(bad));

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bounded wait for the next whole frame
    task automatic wait_frame(input int c0);
        for (waited = 0; waited < 300 && cnt == c0; waited++) begin
            @(negedge clk);
        end
        if (cnt == c0) begin
            errors++;
            $display("Error frame expected %0d seen %0d", c0 + 1, cnt);
            tally_and_finish();
        end
    endtask

    // only enabled priorities carry a meaningful quanta field
    task automatic chk_frame(input logic [7:0] en, input logic [7:0] xon);
        chk("enable", {8'h00, en}, words[0]);
        chk("frame shape", 16'h0000, 16'(bad));
        for (int p = 0; p < NUM_PRIO; p++) begin
            if (en[p]) begin
                chk("quanta", xon[p] ? XON_QUANTA : 16'hA000 + 16'(p), words[p+1]);
            end
        end
    endtask

    task automatic quiet(input int n);
        int c0;
        c0 = cnt;
        repeat (n) @(negedge clk);
        chk("frame count", 16'(c0), 16'(cnt));
    endtask

    task automatic pulse(input int p);
        req[p] = 1'b1;
        @(negedge clk);
        req[p] = 1'b0;
    endtask

    // counts pause cycles of priority 0 and of all others
    task automatic rx_try(input logic [15:0] t, input logic [15:0] q, input int e);
        int n0, n1;
        n0 = 0;
        n1 = 0;
        {rxt, rxe, rxq, rxv} = {t, 16'h0001, {8{q}}, 1'b1};
        @(negedge clk);
        rxv = 1'b0;
        // pause rises on the load edge, so sample before each wait
        repeat (10) begin
            n0 += int'(pause[0] === 1'b1);
            n1 += int'(pause[7:1] !== 7'h00);
            @(negedge clk);
        end
        chk("pause cycles", 16'(e), 16'(n0));
        chk("other pause", 16'h0, 16'(n1));
    endtask

    task automatic t_oneshot();
        int c0;
        c0 = cnt;
        pulse(2);
        wait_frame(c0);
        chk_frame(8'h04, 8'h00);
        quiet(60);
        stall = 1'b1;
        pulse(5);
        repeat (4) @(negedge clk);
        chk("hold", 16'h1, {15'h0, hold});
        quiet(4);
        c0 = cnt;
        stall = 1'b0;
        wait_frame(c0);
        chk_frame(8'h20, 8'h00);
        $display("test oneshot done");
    endtask

    task automatic t_held();
        int c0;
        c0 = cnt;
        req[0] = 1'b1;
        wait_frame(c0);
        chk_frame(8'h01, 8'h00);
        c0 = cnt;
        pulse(3);
        wait_frame(c0);
        chk_frame(8'h09, 8'h00);
        c0 = cnt;
        wait_frame(c0);
        chk_frame(8'h01, 8'h00);
        chk("refresh gap", 16'h1, {15'h0, waited inside {[19:23]}});
        axon = 1'b1;
        c0 = cnt;
        req[0] = 1'b0;
        wait_frame(c0);
        chk_frame(8'h01, 8'h01);
        quiet(60);
        // held release without auto-XON leaves the quanta to expire
        axon = 1'b0;
        c0 = cnt;
        req[6] = 1'b1;
        wait_frame(c0);
        chk_frame(8'h40, 8'h00);
        req[6] = 1'b0;
        quiet(40);
        $display("test held done");
    endtask

    task automatic t_rx();
        rx_try(MAC_CTRL_TYPE, 16'h0003, 3);
        rx_try(16'h8809, 16'h0003, 0);
        rx_en = 1'b0;
        rx_try(MAC_CTRL_TYPE, 16'h0003, 0);
        rx_en = 1'b1;
        $display("test rx done");
    endtask

    task automatic t_disabled();
        pen[4] = 1'b0;
        pulse(4);
        quiet(40);
        tx_en = 1'b0;
        pulse(1);
        quiet(40);
        lp_en = 1'b1;
        tx_en = 1'b1;
        repeat (2) @(negedge clk);
        chk("conflict", 16'h1, {15'h0, conf});
        pulse(1);
        quiet(40);
        $display("test disabled done");
    endtask

    initial begin
        for (int p = 0; p < NUM_PRIO; p++) begin
            pq[16*p +: 16] = 16'hA000 + 16'(p);
        end
        rq = {NUM_PRIO{16'h0014}};
        repeat (6) @(negedge clk);
        chk("reset outputs", 16'h0, 16'({valid, first, last, hold, conf, pause}));
        $display("test reset done");
        rstn = 1'b1;
        @(negedge clk);
        t_oneshot();
        t_held();
        t_rx();
        t_disabled();
        tally_and_finish();
    end
endmodule
